// ---- design/tss_pkg.sv ----
// Package of constants and types for the temperature sensor setup register bank.
package tss_pkg;

   // ****************************************************************
   // Register indices; the byte address is four times the index.
   // ****************************************************************
   localparam logic [3:0] IDX_SENSOR_SETUP = 4'h1;
   localparam logic [3:0] IDX_UPPER_TRIP = 4'h2;
   localparam logic [3:0] IDX_LOWER_TRIP = 4'h3;
   localparam logic [3:0] IDX_CRIT_TRIP = 4'h4;
   localparam logic [3:0] IDX_AMBIENT = 4'h5;
   localparam logic [3:0] IDX_IRQ_STATUS = 4'h9;
   localparam logic [3:0] IDX_IRQ_MASK = 4'ha;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W = 6;

   // ****************************************************************
   // Field layout and reset values.
   // ****************************************************************
   localparam int NUM_LIMITS = 3;
   localparam int LIM_UPPER = 0;
   localparam int LIM_LOWER = 1;
   localparam int LIM_CRIT = 2;
   localparam logic [15:0] LIMIT_MASK = 16'h1ffc;
   localparam logic [15:0] SETUP_RESET = 16'h0000;
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [15:0] AMBIENT_RESET = 16'h0000;
   localparam int NUM_EVENTS = 3;
   localparam int EV_WARN_RISE = 0;
   localparam int EV_SAMPLE = 1;
   localparam int EV_LOCK_REFUSED = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // ****************************************************************
   // Bus answers.
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Types.
   // ****************************************************************
   typedef struct packed {
      logic [4:0] unused;
      logic [1:0] boundary_hysteresis;
      logic low_power_halt;
      logic critical_limit_guard;
      logic window_limit_guard;
      logic event_flag_clear;
      logic warning_pin_state;
      logic warning_pin_enable;
      logic warning_source_select;
      logic warning_pin_polarity;
      logic warning_pin_style;
   } tss_setup_t;

   typedef struct packed {
      logic [15:0] upper_trip_limit;
      logic [15:0] lower_trip_limit;
      logic [15:0] critical_trip_limit;
   } tss_limits_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } tss_sample_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } tss_wr_state_t;

endpackage : tss_pkg

// ---- design/tss_setup_bank.sv ----
// Setup register bank of a temperature monitor with an AXI4-Lite slave port.
// Behaviour
// (RULE1) Sixteen-bit setup register; bits 15 to 11 read zero and ignore writes.
// (RULE2) Bits 10:9 pick boundary hysteresis; frozen while either guard bit is set.
// (RULE3) Hysteresis stays writable during low-power halt when neither guard is set.
// (RULE4) Bit 8 low_power_halt: 0 continuous conversion after reset, 1 halt.
// (RULE5) In halt no new samples are taken; ambient reading keeps last value.
// (RULE6) In halt every register read and write still completes normally.
// (RULE7) Setting halt is ignored while a guard is set; clearing it still works.
// (RULE8) Bit 7 guards the critical limit; bit 6 guards upper and lower limits.
// (RULE9) Guard bits, once set, stay set until reset.
// (RULE10) Bits 5:0 configure the warning pin; all setup bits reset to zero.
// (RULE11) Writing 1 to event_flag_clear releases a latched warning; reads back 0.
// (RULE12) In halt the clear strobe only acts on a pending latched warning.
// (RULE13) warning_pin_style 0 gives comparator output, 1 latched interrupt output.
// (RULE14) warning_pin_polarity 0 gives active-low open drain, 1 active-high.
// (RULE15) Guarded fields keep their value; unguarded bits of that write still update.
`timescale 1ns/1ps

module tss_setup_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [tss_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tss_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire tss_pkg::tss_sample_t sample_in,
   input wire logic crit_trip,
   input wire logic window_trip,
   output tss_pkg::tss_limits_t trip_limits,
   output logic [1:0] boundary_hysteresis,
   output logic conversion_enable,
   output logic warning_pin_o,
   output logic warning_pin_oe,
   output logic irq
);
   import tss_pkg::*;

   // ****************************************************************
   // Storage.
   // ****************************************************************
   tss_setup_t setup;
   logic [15:0] limit [NUM_LIMITS];
   logic [15:0] ambient_reading;
   logic [NUM_EVENTS-1:0] irq_status;
   logic [NUM_EVENTS-1:0] irq_mask;
   logic warn_active;
   logic trip_prev;
   tss_wr_state_t wr_state;

   logic wr_fire;
   logic [3:0] wr_idx;
   logic [31:0] wr_merged;
   logic wr_mapped;
   logic rd_fire;
   logic [3:0] rd_idx;
   tss_setup_t next_setup;
   logic next_refused;
   logic clear_strobe;
   logic trip_raw;
   logic next_warn;
   logic [NUM_EVENTS-1:0] ev;
   logic [NUM_LIMITS-1:0] lim_refused;

   // ****************************************************************
   // Decoding.
   // ****************************************************************
   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = addr[ADDR_W-1:ADDR_LSB];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [3:0] idx);
      is_mapped = (idx == IDX_SENSOR_SETUP) || (idx == IDX_UPPER_TRIP) ||
                  (idx == IDX_LOWER_TRIP) || (idx == IDX_CRIT_TRIP) ||
                  (idx == IDX_AMBIENT) || (idx == IDX_IRQ_STATUS) ||
                  (idx == IDX_IRQ_MASK);
   endfunction : is_mapped

   function automatic logic [31:0] strobe_merge(input logic [31:0] old,
                                                input logic [31:0] wdata,
                                                input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      strobe_merge = r;
   endfunction : strobe_merge

   // ****************************************************************
   // Write channel: address and data are taken together in one beat.
   // ****************************************************************
   assign wr_fire = s_axi_awvalid && s_axi_wvalid && (wr_state == WR_IDLE) &&
                    !s_axi_awready;
   assign wr_idx = reg_index(s_axi_awaddr);
   assign wr_mapped = is_mapped(wr_idx);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= WR_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= wr_fire;
         s_axi_wready <= wr_fire;
         case (wr_state)
            WR_IDLE: begin
               if (wr_fire) begin
                  wr_state <= WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR; // see (RULE6)
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state <= WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Setup register write filter.
   // ****************************************************************
   always_comb begin
      tss_setup_t v;
      logic locked;
      v = tss_setup_t'(16'h0000);
      locked = setup.critical_limit_guard || setup.window_limit_guard;
      wr_merged = strobe_merge({16'h0000, setup}, s_axi_wdata, s_axi_wstrb);
      v = tss_setup_t'(wr_merged[15:0]);
      next_setup = setup;
      next_refused = 1'b0;
      clear_strobe = 1'b0;
      if (wr_fire && (wr_idx == IDX_SENSOR_SETUP)) begin
         if (!locked) begin
            next_setup.boundary_hysteresis = v.boundary_hysteresis; // see (RULE2) (RULE3)
            next_setup.warning_pin_enable = v.warning_pin_enable;
            next_setup.warning_pin_polarity = v.warning_pin_polarity;
         end else if ((v.boundary_hysteresis != setup.boundary_hysteresis) ||
                      (v.warning_pin_enable != setup.warning_pin_enable) ||
                      (v.warning_pin_polarity != setup.warning_pin_polarity)) begin
            next_refused = 1'b1; // see (RULE15)
         end
         if (!v.low_power_halt) begin
            next_setup.low_power_halt = 1'b0; // see (RULE7)
         end else if (!locked) begin
            next_setup.low_power_halt = 1'b1; // see (RULE4)
         end else if (!setup.low_power_halt) begin
            next_refused = 1'b1; // see (RULE7)
         end
         if (!setup.window_limit_guard) begin
            next_setup.warning_source_select = v.warning_source_select;
         end else if (v.warning_source_select != setup.warning_source_select) begin
            next_refused = 1'b1; // see (RULE15)
         end
         // Guards can only be raised here; only reset lowers them.
         next_setup.critical_limit_guard = setup.critical_limit_guard |
                                           v.critical_limit_guard; // see (RULE9)
         next_setup.window_limit_guard = setup.window_limit_guard |
                                         v.window_limit_guard; // see (RULE9)
         next_setup.warning_pin_style = v.warning_pin_style; // see (RULE13)
         clear_strobe = v.event_flag_clear && s_axi_wstrb[0] &&
                        (!setup.low_power_halt || warn_active); // see (RULE12)
      end
      next_setup.unused = 5'h00; // see (RULE1)
      next_setup.event_flag_clear = 1'b0; // see (RULE11)
      next_setup.warning_pin_state = next_warn;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         setup <= tss_setup_t'(SETUP_RESET); // see (RULE10)
      end else begin
         setup <= next_setup;
      end
   end

   // ****************************************************************
   // Trip limits, each guarded by its lock bit.
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_limit
         localparam logic [3:0] MY_IDX = IDX_UPPER_TRIP + 4'(gi);
         logic guard;
         logic [31:0] merged;
         assign guard = (gi == LIM_CRIT) ? setup.critical_limit_guard :
                                           setup.window_limit_guard; // see (RULE8)
         assign merged = strobe_merge({16'h0000, limit[gi]}, s_axi_wdata, s_axi_wstrb);
         assign lim_refused[gi] = wr_fire && (wr_idx == MY_IDX) && guard;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               limit[gi] <= LIMIT_RESET;
            end else if (wr_fire && (wr_idx == MY_IDX) && !guard) begin
               limit[gi] <= merged[15:0] & LIMIT_MASK; // see (RULE8)
            end
         end
      end
   endgenerate

   assign trip_limits.upper_trip_limit = limit[LIM_UPPER];
   assign trip_limits.lower_trip_limit = limit[LIM_LOWER];
   assign trip_limits.critical_trip_limit = limit[LIM_CRIT];

   // ****************************************************************
   // Conversion capture.
   // ****************************************************************
   // Samples arriving during halt are dropped, so the reading stays frozen.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ambient_reading <= AMBIENT_RESET;
      end else if (sample_in.valid && !setup.low_power_halt) begin
         ambient_reading <= sample_in.data; // see (RULE5)
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conversion_enable <= 1'b0;
         boundary_hysteresis <= 2'h0;
      end else begin
         conversion_enable <= !next_setup.low_power_halt; // see (RULE5)
         boundary_hysteresis <= next_setup.boundary_hysteresis; // see (RULE2)
      end
   end

   // ****************************************************************
   // Warning output.
   // ****************************************************************
   assign trip_raw = setup.warning_pin_enable &&
                     (crit_trip || (!setup.warning_source_select && window_trip));

   always_comb begin
      next_warn = warn_active;
      if (setup.low_power_halt) begin
         // The warning state is frozen in halt; only a latched warning may be released.
         if (clear_strobe && setup.warning_pin_style) begin
            next_warn = 1'b0; // see (RULE12)
         end
      end else if (!setup.warning_pin_style) begin
         next_warn = trip_raw; // see (RULE13)
      end else if (trip_raw && !trip_prev) begin
         next_warn = 1'b1; // see (RULE13)
      end else if (clear_strobe) begin
         next_warn = 1'b0; // see (RULE11)
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warn_active <= 1'b0;
         trip_prev <= 1'b0;
         warning_pin_o <= 1'b0;
         warning_pin_oe <= 1'b0;
      end else begin
         warn_active <= next_warn;
         trip_prev <= setup.low_power_halt ? trip_prev : trip_raw;
         // Active-low drives only while asserted and relies on an external pull-up.
         warning_pin_o <= next_setup.warning_pin_polarity & next_warn; // see (RULE14)
         warning_pin_oe <= next_setup.warning_pin_polarity | next_warn; // see (RULE14)
      end
   end

   // ****************************************************************
   // Interrupt status and mask.
   // ****************************************************************
   always_comb begin
      ev = '0;
      ev[EV_WARN_RISE] = next_warn && !warn_active;
      ev[EV_SAMPLE] = sample_in.valid && !setup.low_power_halt;
      ev[EV_LOCK_REFUSED] = next_refused || (|lim_refused);
   end

   // A new event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= IRQ_RESET;
      end else if (wr_fire && (wr_idx == IDX_IRQ_STATUS)) begin
         irq_status <= (irq_status & ~(s_axi_wdata[NUM_EVENTS-1:0] &
                       {NUM_EVENTS{s_axi_wstrb[0]}})) | ev;
      end else begin
         irq_status <= irq_status | ev;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= IRQ_RESET;
      end else if (wr_fire && (wr_idx == IDX_IRQ_MASK) && s_axi_wstrb[0]) begin
         irq_mask <= s_axi_wdata[NUM_EVENTS-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ****************************************************************
   // Read channel.
   // ****************************************************************
   assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   assign rd_idx = reg_index(s_axi_araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR; // see (RULE6)
            case (rd_idx)
               IDX_SENSOR_SETUP: s_axi_rdata <= {16'h0000, setup}; // see (RULE1)
               IDX_UPPER_TRIP: s_axi_rdata <= {16'h0000, limit[LIM_UPPER]};
               IDX_LOWER_TRIP: s_axi_rdata <= {16'h0000, limit[LIM_LOWER]};
               IDX_CRIT_TRIP: s_axi_rdata <= {16'h0000, limit[LIM_CRIT]};
               IDX_AMBIENT: s_axi_rdata <= {16'h0000, ambient_reading};
               IDX_IRQ_STATUS: s_axi_rdata <= {29'h000_0000, irq_status};
               IDX_IRQ_MASK: s_axi_rdata <= {29'h000_0000, irq_mask};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : tss_setup_bank

// ---- tb/tss_setup_bank_sva.sv ----
// Port checker for the setup register bank, bound to every instance.
`timescale 1ns/1ps
module tss_setup_bank_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire tss_pkg::tss_limits_t trip_limits,
   input wire logic [1:0] boundary_hysteresis,
   input wire logic conversion_enable
);
   import tss_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_taken;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
         |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
   endproperty
   a_wr_taken: assert property (p_wr_taken) else $error("write not answered");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_taken;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
   endproperty
   a_rd_taken: assert property (p_rd_taken) else $error("read not answered");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data unstable");
   property p_ar_pulse;
      s_axi_arready |=> !s_axi_arready;
   endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("read ready too long");
   property p_conv_reset;
      !$past(aresetn) |-> !conversion_enable ##1 conversion_enable;
   endproperty
   a_conv_reset: assert property (p_conv_reset) else $error("conversion not on");
   // Reset edges are excluded because the register falls back without a bus write.
   property p_conv_cause;
      !$stable(conversion_enable) && $past(aresetn, 2) |-> s_axi_awready;
   endproperty
   a_conv_cause: assert property (p_conv_cause) else $error("mode moved alone");
   property p_hyst_cause;
      !$stable(boundary_hysteresis) && $past(aresetn) |-> s_axi_awready;
   endproperty
   a_hyst_cause: assert property (p_hyst_cause) else $error("hysteresis moved");
   property p_lim_cause;
      !$stable(trip_limits) && $past(aresetn) |-> s_axi_awready;
   endproperty
   a_lim_cause: assert property (p_lim_cause) else $error("limit moved alone");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_halt: cover property ($fell(conversion_enable));
endmodule : tss_setup_bank_sva
bind tss_setup_bank tss_setup_bank_sva chk_u (.*);

// ---- tb/tss_host_model.sv ----
// Bus master model of the host that programs the register bank.
`timescale 1ns/1ps
module tss_host_model (
   input wire logic aclk,
   output logic [5:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [5:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // Released payloads are inverted so a late sampler never sees stale values.
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : tss_host_model

// ---- tb/tss_setup_bank_test.sv ----
// Self-checking bench of the setup register bank.
`timescale 1ns/1ps
`define check_eq(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tss_setup_bank_test;
   import tss_pkg::*;
   logic aclk, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, old_up, old_crit;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, boundary_hysteresis;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic aresetn = 1'b0;
   logic crit_trip = 1'b0;
   logic window_trip = 1'b0;
   tss_sample_t sample_in = '0;
   tss_limits_t trip_limits;
   logic conversion_enable, warning_pin_o, warning_pin_oe, irq;
   logic [33:0] exp_q[$];
   logic [33:0] got, want;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   tss_setup_bank dut_u (.*);
   tss_host_model host_u (.*);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ****************************************************************
   // Bus helpers, result monitor and closing.
   // ****************************************************************
   task automatic wr(input logic [3:0] i, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, 32'h0000_0000});
      host_u.wr({i, 2'b00}, d);
   endtask : wr
   task automatic rd(input logic [3:0] i, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, d});
      host_u.rd({i, 2'b00});
   endtask : rd
   task automatic pin(input logic [2:0] e);
      repeat (3) @(posedge aclk);
      #1 `check_eq({warning_pin_oe, warning_pin_o, irq}, e)
      // Return on an edge so the next stimulus lands on a rising edge.
      @(posedge aclk);
   endtask : pin
   always @(posedge aclk) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         got = s_axi_bvalid ? {s_axi_bresp, 32'h0000_0000} : {s_axi_rresp, s_axi_rdata};
         want = exp_q.pop_front();
         `check_eq(got, want)
      end
   end
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // A run of a few hundred bus cycles ends long before this ceiling.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      void'($urandom(27510));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 1; i <= 5; i++) rd(i[3:0], 32'h0000_0000, RESP_OKAY);
      wr(IDX_SENSOR_SETUP, 32'hffff_fe30, RESP_OKAY);
      rd(IDX_SENSOR_SETUP, 32'h0000_0600, RESP_OKAY);
      for (int i = 2; i <= 4; i++) begin
         rv = $urandom;
         wr(i[3:0], rv, RESP_OKAY);
         rd(i[3:0], rv & {16'h0000, LIMIT_MASK}, RESP_OKAY);
         if (i == 2) old_up = rv & {16'h0000, LIMIT_MASK};
      end
      old_crit = rv & {16'h0000, LIMIT_MASK};
      rd(4'h6, 32'h0000_0000, RESP_SLVERR);
      wr(4'h6, 32'h0000_ffff, RESP_SLVERR);
      wr(IDX_SENSOR_SETUP, 32'h0000_0008, RESP_OKAY);
      wr(IDX_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
      wr(IDX_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
      pin(3'b000);
      crit_trip <= 1'b1;
      pin(3'b101);
      wr(IDX_SENSOR_SETUP, 32'h0000_000a, RESP_OKAY);
      pin(3'b111);
      crit_trip <= 1'b0;
      wr(IDX_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
      pin(3'b100);
      // Source select on: the window comparator must not reach the pin.
      wr(IDX_SENSOR_SETUP, 32'h0000_000e, RESP_OKAY);
      window_trip <= 1'b1;
      pin(3'b100);
      wr(IDX_SENSOR_SETUP, 32'h0000_000a, RESP_OKAY);
      pin(3'b111);
      window_trip <= 1'b0;
      wr(IDX_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
      pin(3'b100);
      wr(IDX_SENSOR_SETUP, 32'h0000_000b, RESP_OKAY);
      crit_trip <= 1'b1;
      pin(3'b111);
      crit_trip <= 1'b0;
      pin(3'b111);
      wr(IDX_SENSOR_SETUP, 32'h0000_002b, RESP_OKAY);
      pin(3'b101);
      rd(IDX_SENSOR_SETUP, 32'h0000_000b, RESP_OKAY);
      // A latched warning survives entry to halt and is released there by the strobe.
      crit_trip <= 1'b1;
      pin(3'b111);
      wr(IDX_SENSOR_SETUP, 32'h0000_010b, RESP_OKAY);
      pin(3'b111);
      wr(IDX_SENSOR_SETUP, 32'h0000_012b, RESP_OKAY);
      pin(3'b101);
      rd(IDX_SENSOR_SETUP, 32'h0000_010b, RESP_OKAY);
      crit_trip <= 1'b0;
      wr(IDX_SENSOR_SETUP, 32'h0000_0000, RESP_OKAY);
      sample_in <= '{valid: 1'b1, data: 16'h0190};
      @(posedge aclk);
      sample_in <= '{valid: 1'b0, data: 16'h0000};
      rd(IDX_AMBIENT, 32'h0000_0190, RESP_OKAY);
      wr(IDX_SENSOR_SETUP, 32'h0000_0100, RESP_OKAY);
      sample_in <= '{valid: 1'b1, data: 16'h0aa0};
      #1 `check_eq(conversion_enable, 1'b0)
      @(posedge aclk);
      sample_in <= '{valid: 1'b0, data: 16'h0000};
      rd(IDX_AMBIENT, 32'h0000_0190, RESP_OKAY);
      wr(IDX_SENSOR_SETUP, 32'h0000_0500, RESP_OKAY);
      rd(IDX_SENSOR_SETUP, 32'h0000_0500, RESP_OKAY);
      wr(IDX_SENSOR_SETUP, 32'h0000_05c0, RESP_OKAY);
      wr(IDX_SENSOR_SETUP, 32'h0000_0201, RESP_OKAY);
      rd(IDX_SENSOR_SETUP, 32'h0000_04c1, RESP_OKAY);
      wr(IDX_SENSOR_SETUP, 32'h0000_0103, RESP_OKAY);
      rd(IDX_SENSOR_SETUP, 32'h0000_04c1, RESP_OKAY);
      wr(IDX_UPPER_TRIP, $urandom, RESP_OKAY);
      rd(IDX_UPPER_TRIP, old_up, RESP_OKAY);
      wr(IDX_CRIT_TRIP, 32'h0000_0004, RESP_OKAY);
      rd(IDX_CRIT_TRIP, old_crit, RESP_OKAY);
      `check_eq(boundary_hysteresis, 2'h2)
      `check_eq(trip_limits.upper_trip_limit, old_up[15:0])
      `check_eq(trip_limits.critical_trip_limit, old_crit[15:0])
      rd(IDX_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
      rd(IDX_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(IDX_SENSOR_SETUP, 32'h0000_0000, RESP_OKAY);
      repeat (2) @(posedge aclk);
      report_and_stop();
   end
endmodule : tss_setup_bank_test
